/* src/ring_trip_defines.svh */
// register indices, field positions, filter scale and timing counts
// assumes a 100 MHz clock and word-aligned AHB-Lite register access
// Summary of operation
// [R1] The offset joins the ringing wave only while offset enable is one.
// [R2] The offset value is the offset voltage over 96 V times 2**15.
// [R3] While ringing, common mode is half of battery minus headroom.
// [R4] Headroom is a 4-bit field of 1.5 V steps below the battery rail.
// [R5] With boost set, the current limit rises briefly on leaving ringing.
// [R6] Loop current samples are processed only while linefeed is ringing.
// [R7] Samples pass a low-pass filter with a 13-bit coefficient first.
// [R8] The filtered value is compared to the 6-bit threshold for debounce.
// [R9] The debouncer flips only after the opposite state holds all interval.
// [R10] A satisfied interval sets the read-only trip detect status bit.
// [R11] A valid trip sets the pending interrupt only when enabled.
// [R12] Software picks coefficient, threshold and debounce by frequency.
// [R13] Software sets the battery setting above the peak ringing voltage.
// [R14] Software loads headroom with the computed overhead voltage.
// [R15] Linefeed select 100 enters ringing, which trip processing needs.
// [R16] Software reaches indirect fields through the indirect access regs; here each such field has its own register index.
// [R17] The debounce timer restarts when the comparator rejoins the output.
`ifndef RING_TRIP_DEFINES_SVH
`define RING_TRIP_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_IRQ_PENDING   8'h13
`define IDX_IRQ_ENABLE    8'h16
`define IDX_RING_CTRL     8'h22
`define IDX_LINEFEED      8'h40
`define IDX_TRIP_STATUS   8'h44
`define IDX_DEBOUNCE      8'h46
`define IDX_BATTERY       8'h4A
`define IDX_LOOP_CURRENT  8'h4F
`define IDX_BOOST         8'h6C
`define IDX_OFFSET        8'h86
`define IDX_THRESHOLD     8'h90
`define IDX_FILTER_COEF   8'h97
`define IDX_HEADROOM      8'h9B

// field positions
`define BIT_TRIP_IRQ      0
`define BIT_OFFSET_EN     1
`define BIT_BOOST_EN      7
`define LINEFEED_RINGING  3'b100

// filter scale: coefficient weight is coef / 2**FILTER_SHIFT
`define FILTER_SHIFT      15
`define THRESH_LSB        10

// debounce tick period and current boost duration
`define TICK_TIME_US      1000
`define BOOST_TIME_US     10
`define CLOCK_MHZ         100
`define TICK_CYCLES       (`TICK_TIME_US * `CLOCK_MHZ)
`define BOOST_CYCLES      (`BOOST_TIME_US * `CLOCK_MHZ)

`endif

/* src/ring_trip_pkg.sv */
// types shared by the ring trip and offset block
// assumes the defines header supplies every number
package ring_trip_pkg;

  typedef struct packed {
    logic [2:0]  linefeed_select;
    logic        offset_enable_bit;
    logic        transition_current_boost;
    logic        trip_interrupt_enable;
    logic        trip_interrupt_pending;
    logic [6:0]  trip_debounce_interval;
    logic [5:0]  high_battery_setting;
    logic [15:0] ringing_offset_value;
    logic [5:0]  trip_threshold;
    logic [12:0] trip_filter_coefficient;
    logic [3:0]  ringing_headroom_setting;
    logic [15:0] loop_current_sense;
    logic [15:0] filtered;
    logic [6:0]  debounce_count;
    logic        trip_detect_status;
    logic [16:0] tick_count;
    logic [9:0]  boost_count;
    logic        was_ringing;
    logic        write_pending;
    logic [7:0]  write_index;
    logic [31:0] hrdata;
    logic [15:0] ring_drive;
    logic [6:0]  common_mode;
  } ring_state_t;

endpackage

/* src/ring_trip_detect_offset.sv */
// ringing offset, common-mode level, boost and ring trip detector
// assumes AHB-Lite single word transfers and synchronous sample inputs
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`include "ring_trip_defines.svh"

module ring_trip_detect_offset #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:0] ring_wave,
  input  wire logic [15:0] loop_current_sample,
  input  wire logic        sample_valid,
  output logic [15:0]      ring_drive,
  output logic [6:0]       common_mode,
  output logic             current_limit_boost,
  output logic             trip_detect_status,
  output logic             trip_irq
);

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  localparam logic [9:0]  BOOST_LEN = 10'(`BOOST_CYCLES);

  ring_trip_pkg::ring_state_t state;
  ring_trip_pkg::ring_state_t next_state;

  logic               ringing;
  logic               addr_phase;
  logic [7:0]         addr_index;
  logic [31:0]        read_value;
  logic signed [16:0] sum_drive;
  logic signed [17:0] diff;
  logic signed [31:0] product;
  logic signed [17:0] step;
  logic               compare_high;
  logic               tick;
  logic               trip_set;
  logic signed [7:0]  cm_diff;

  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = state.hrdata;
  assign ring_drive          = state.ring_drive;
  assign common_mode         = state.common_mode;
  assign current_limit_boost = (state.boost_count != 10'h000);
  assign trip_detect_status  = state.trip_detect_status;
  assign trip_irq            = state.trip_interrupt_pending;

  // [R15] ringing state select
  assign ringing    = (state.linefeed_select == `LINEFEED_RINGING);
  assign addr_phase = hsel & hready & htrans[1];
  assign addr_index = haddr[9:2];
  assign tick       = (state.tick_count == TICK_LAST);

  always_comb begin
    read_value = 32'h0000_0000;
    case (addr_index)
      `IDX_IRQ_PENDING:  read_value[`BIT_TRIP_IRQ] =
                           state.trip_interrupt_pending;
      `IDX_IRQ_ENABLE:   read_value[`BIT_TRIP_IRQ] =
                           state.trip_interrupt_enable;
      `IDX_RING_CTRL:    read_value[`BIT_OFFSET_EN] =
                           state.offset_enable_bit;
      `IDX_LINEFEED:     read_value[2:0] = state.linefeed_select;
      `IDX_TRIP_STATUS:  read_value[0] = state.trip_detect_status;
      `IDX_DEBOUNCE:     read_value[6:0] = state.trip_debounce_interval;
      `IDX_BATTERY:      read_value[5:0] = state.high_battery_setting;
      `IDX_LOOP_CURRENT: read_value[15:0] = state.loop_current_sense;
      `IDX_BOOST:        read_value[`BIT_BOOST_EN] =
                           state.transition_current_boost;
      `IDX_OFFSET:       read_value[15:0] = state.ringing_offset_value;
      `IDX_THRESHOLD:    read_value[5:0] = state.trip_threshold;
      `IDX_FILTER_COEF:  read_value[12:0] = state.trip_filter_coefficient;
      `IDX_HEADROOM:     read_value[3:0] = state.ringing_headroom_setting;
      default:           read_value = 32'h0000_0000;
    endcase
  end

  always_comb begin
    // [R1] offset only when enabled
    sum_drive = state.offset_enable_bit ?
                17'(signed'(ring_wave)) +
                17'(signed'(state.ringing_offset_value)) :
                17'(signed'(ring_wave));
    // [R7] first-order low-pass update
    diff    = 18'(signed'({1'b0, loop_current_sample})) -
              18'(signed'({1'b0, state.filtered}));
    product = 32'(diff) * 32'(signed'({1'b0,
              state.trip_filter_coefficient}));
    step    = 18'(product >>> `FILTER_SHIFT);
    // [R8] threshold compare
    compare_high = (state.filtered[15:`THRESH_LSB] > state.trip_threshold);
    // [R3] common mode in 0.75 V steps
    cm_diff = 8'({2'b00, state.high_battery_setting}) -
              8'({4'h0, state.ringing_headroom_setting});
    trip_set = 1'b0;
    next_state = state;

    // data phase completes the write latched in the address phase
    next_state.write_pending = addr_phase & hwrite;
    if (addr_phase) begin
      next_state.write_index = addr_index;
    end
    if (addr_phase & ~hwrite) begin
      next_state.hrdata = read_value;
    end
    if (state.write_pending) begin
      case (state.write_index)
        `IDX_IRQ_ENABLE:  next_state.trip_interrupt_enable =
                            hwdata[`BIT_TRIP_IRQ];
        `IDX_RING_CTRL:   next_state.offset_enable_bit =
                            hwdata[`BIT_OFFSET_EN];
        `IDX_LINEFEED:    next_state.linefeed_select = hwdata[2:0];
        `IDX_DEBOUNCE:    next_state.trip_debounce_interval = hwdata[6:0];
        `IDX_BATTERY:     next_state.high_battery_setting = hwdata[5:0];
        `IDX_BOOST:       next_state.transition_current_boost =
                            hwdata[`BIT_BOOST_EN];
        // [R2] offset scaled by 2**15 over 96 V
        `IDX_OFFSET:      next_state.ringing_offset_value = hwdata[15:0];
        `IDX_THRESHOLD:   next_state.trip_threshold = hwdata[5:0];
        `IDX_FILTER_COEF: next_state.trip_filter_coefficient =
                            hwdata[12:0];
        // [R4] 1.5 V per step headroom
        `IDX_HEADROOM:    next_state.ringing_headroom_setting =
                            hwdata[3:0];
        // read-only and unmapped indices ignore writes; keep the new
        // address phase index intact for back-to-back transfers
        default:          ;
      endcase
    end

    // [R1] saturate rather than wrap
    if (sum_drive > 17'sh0_7FFF) begin
      next_state.ring_drive = 16'h7FFF;
    end else if (sum_drive < -17'sh0_8000) begin
      next_state.ring_drive = 16'h8000;
    end else begin
      next_state.ring_drive = sum_drive[15:0];
    end
    // [R3] balanced common mode
    next_state.common_mode = (cm_diff[7] | ~ringing) ? 7'h00 : cm_diff[6:0];

    // [R5] boost on leaving ringing
    next_state.was_ringing = ringing;
    if (state.was_ringing & ~ringing & state.transition_current_boost) begin
      next_state.boost_count = BOOST_LEN;
    end else if (state.boost_count != 10'h000) begin
      next_state.boost_count = state.boost_count - 10'h001;
    end

    next_state.tick_count = tick ? 17'h0_0000 :
                            state.tick_count + 17'h0_0001;

    // [R6] detector runs only while ringing
    if (!ringing) begin
      next_state.filtered           = 16'h0000;
      next_state.debounce_count     = 7'h00;
      next_state.trip_detect_status = 1'b0;
    end else begin
      if (sample_valid) begin
        next_state.loop_current_sense = loop_current_sample;
        next_state.filtered = 16'(18'(state.filtered) + step);
      end
      // [R17] restart when comparator agrees
      if (compare_high == state.trip_detect_status) begin
        next_state.debounce_count = 7'h00;
      end else if (tick) begin
        // [R9] flip after full interval
        if (state.debounce_count + 7'h01 >=
            state.trip_debounce_interval) begin
          next_state.debounce_count     = 7'h00;
          next_state.trip_detect_status = compare_high;
          // [R10] valid trip reported
          trip_set = compare_high;
        end else begin
          next_state.debounce_count = state.debounce_count + 7'h01;
        end
      end
    end

    // [R11] pending only when enabled; a new trip beats the clear
    if (state.write_pending && state.write_index == `IDX_IRQ_PENDING &&
        hwdata[`BIT_TRIP_IRQ]) begin
      next_state.trip_interrupt_pending = 1'b0;
    end
    if (trip_set & state.trip_interrupt_enable) begin
      next_state.trip_interrupt_pending = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

/* tb/ring_trip_chk.sv */
// port checker for the ring trip block
// assumes it is bound to the block with its ports by name
module ring_trip_chk (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        current_limit_boost,
  input wire logic        trip_detect_status,
  input wire logic        trip_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] high_len;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      high_len <= 11'h000;
    end else if (current_limit_boost) begin
      high_len <= high_len + 11'h001;
    end else begin
      high_len <= 11'h000;
    end
  end

  AST_READY: assert property (hreadyout) else $error("ready low");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_RDATA_HOLD: assert property (!(hsel && hready && htrans[1] && !hwrite)
    |=> $stable(hrdata)) else $error("read data moved");
  AST_BOOST_HOLD: assert property ($rose(current_limit_boost) |->
    current_limit_boost[*8]) else $error("boost too short");
  AST_BOOST_LEN: assert property ($fell(current_limit_boost) |->
    high_len == 11'h3E8) else $error("boost length wrong");
  AST_BOOST_CAP: assert property (high_len <= 11'h3E8)
    else $error("boost too long");
  AST_IRQ_CAUSE: assert property ($rose(trip_irq) |->
    trip_detect_status) else $error("irq without trip");
  AST_IRQ_CLEAR: assert property ($fell(trip_irq) |->
    $past(hsel && hready && htrans[1] && hwrite, 2))
    else $error("irq fell without write");
endmodule

bind ring_trip_detect_offset ring_trip_chk chk (.clock, .resetn, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .current_limit_boost, .trip_detect_status, .trip_irq);

/* tb/line_model.sv */
// subscriber line model: ringing wave and loop current samples
// assumes the bench raises off_hook when the handset is lifted
module line_model (
  input  wire logic   clock,
  input  wire logic   resetn,
  input  wire logic   off_hook,
  output logic [15:0] ring_wave,
  output logic [15:0] loop_current_sample,
  output logic        sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign sample_valid = (phase == 2'h3);
  assign ring_wave = 16'h0123;
  // no stale value between samples: a moving pattern instead
  assign loop_current_sample = !sample_valid ? {14'h0000, phase} ^ 16'hA5A5
                             : off_hook ? 16'h7000 : 16'h0100;
endmodule

/* tb/test_ring_trip_detect_offset.sv */
// bench for the ring trip block: bus tasks and scenarios
// assumes the line model on the sample side and the bound checker
`include "ring_trip_defines.svh"
module test_ring_trip_detect_offset;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        off_hook = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, sample_valid, current_limit_boost;
  logic        trip_detect_status, trip_irq;
  logic [15:0] ring_wave, loop_current_sample, ring_drive;
  logic [6:0]  common_mode;
  int          fail_count = 0, n_compared = 0, cycles = 0, t;

  always #5 clock = ~clock;

  ring_trip_detect_offset #(.TICK_CYCLES(8)) uut (.clock, .resetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .ring_wave, .loop_current_sample,
    .sample_valid, .ring_drive, .common_mode, .current_limit_boost,
    .trip_detect_status, .trip_irq);
  line_model line (.clock, .resetn, .off_hook, .ring_wave,
    .loop_current_sample, .sample_valid);

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h00_0000, idx, 2'h0};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] idx,
                     input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(what, rd, exp);
  endtask

  // sampled between edges so the flag has settled
  task automatic wait_trip(input logic lvl);
    t = 0;
    while (trip_detect_status !== lvl && t < 3000) begin
      @(negedge clock);
      t++;
    end
    @(posedge clock);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rdc("unmapped", 8'h05, 32'h0);
    rdc("status", `IDX_TRIP_STATUS, 32'h0);
    wr(`IDX_BATTERY, 32'h28);
    wr(`IDX_HEADROOM, 32'h4);
    wr(`IDX_FILTER_COEF, 32'h0320);
    wr(`IDX_DEBOUNCE, 32'h0B);
    wr(`IDX_THRESHOLD, 32'h3F);
    wr(`IDX_IRQ_ENABLE, 32'h1);
    wr(`IDX_OFFSET, 32'h0100);
    repeat (2) @(posedge clock);
    check("drive off", ring_drive, 16'h0123);
    wr(`IDX_RING_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    check("drive on", ring_drive, 16'h0223);
    off_hook <= 1'b1;
    repeat (400) @(posedge clock);
    check("idle trip", trip_detect_status, 1'b0);
    check("idle cm", common_mode, 7'h00);
    rdc("idle lcs", `IDX_LOOP_CURRENT, 32'h0);
    wr(`IDX_LINEFEED, 32'h4);
    // filter settles above trip level, threshold still out of reach
    repeat (400) @(posedge clock);
    check("high thr", trip_detect_status, 1'b0);
    wr(`IDX_THRESHOLD, 32'h14);
    repeat (40) @(posedge clock);
    // a short comparator drop must restart the count
    wr(`IDX_THRESHOLD, 32'h3F);
    wr(`IDX_THRESHOLD, 32'h14);
    wait_trip(1'b1);
    // 11 ticks of 8 cycles, first tick 1..8 cycles after the compare
    check("debounce", (t >= 82) && (t <= 89), 1'b1);
    check("cm", common_mode, 7'h24);
    check("irq", trip_irq, 1'b1);
    wr(`IDX_TRIP_STATUS, 32'h0);
    rdc("status ro", `IDX_TRIP_STATUS, 32'h1);
    rdc("pending", `IDX_IRQ_PENDING, 32'h1);
    rdc("lcs", `IDX_LOOP_CURRENT, 32'h7000);
    wr(`IDX_IRQ_PENDING, 32'h1);
    @(posedge clock);
    check("irq clr", trip_irq, 1'b0);
    off_hook <= 1'b0;
    repeat (50) @(posedge clock);
    check("hold", trip_detect_status, 1'b1);
    wait_trip(1'b0);
    check("release", trip_detect_status, 1'b0);
    check("no irq", trip_irq, 1'b0);
    wr(`IDX_IRQ_ENABLE, 32'h0);
    off_hook <= 1'b1;
    wait_trip(1'b1);
    check("masked", trip_irq, 1'b0);
    wr(`IDX_BOOST, 32'h80);
    wr(`IDX_LINEFEED, 32'h0);
    @(posedge clock);
    @(negedge clock);
    check("boost", current_limit_boost, 1'b1);
    check("leave", trip_detect_status, 1'b0);
    check("cm off", common_mode, 7'h00);
    repeat (1005) @(posedge clock);
    check("boost end", current_limit_boost, 1'b0);
    end_of_test();
  end
endmodule
